// ===== src/cmsm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmsm_params.svh"
module cmsm_top
  import cmsm_pkg::*;
#(
  parameter logic [1:0] CORR_MODE   = `CMSM_MODE_REPAIR,
  parameter bit         CLASSIFY_EN = 1'b1,
  parameter bit         INJECT_EN   = 1'b1,
  parameter int         BOOT_CYC    = `CMSM_BOOT_CYC,
  parameter int         INIT_RR     = `CMSM_INIT_CYC_RR,
  parameter int         INIT_ENH    = `CMSM_INIT_CYC_ENH,
  parameter int         FRAME_WORDS = `CMSM_FRAME_WORDS
)(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          user_mode,
  input  wire cmsm_det_t     det,
  output logic               det_ready,
  input  wire logic          inj_valid,
  input  wire logic [15:0]   inj_frame,
  input  wire logic [7:0]    inj_word,
  input  wire logic [4:0]    inj_bit,
  output logic               inj_ready,
  output cmsm_cap_req_t      cap_req,
  input  wire logic          cap_ack,
  input  wire logic [31:0]   cap_rdata,
  output cmsm_ext_req_t      ext_req,
  input  wire logic          ext_ack,
  input  wire logic [31:0]   ext_rdata,
  output cmsm_rpt_t          rpt,
  output logic               startup_done,
  output logic               busy
);
  localparam int INIT_CYC = (CORR_MODE == `CMSM_MODE_ENH) ? INIT_ENH
                                                          : INIT_RR;

  cmsm_state_t   st_r, st_nxt;
  logic [31:0]   cnt_r, cnt_nxt;
  logic          started_r, started_nxt;
  cmsm_det_t     det_r, det_nxt;
  logic          inj_r, inj_nxt;
  logic          ok_r, ok_nxt;
  logic          ess_r, ess_nxt;
  logic [7:0]    widx_r, widx_nxt;
  cmsm_cap_req_t cap_r, cap_nxt;
  cmsm_ext_req_t ext_r, ext_nxt;
  cmsm_rpt_t     rpt_r, rpt_nxt;
  logic [31:0]   fix_word;
  logic          fix_ok;
  logic          det_take;
  logic          inj_take;

  cmsm_fix u_fix (
    .mode  (CORR_MODE),
    .inj   (inj_r),
    .det   (det_r),
    .rdata (cap_rdata),
    .fixed (fix_word),
    .ok    (fix_ok)
  );

  assign det_ready    = (st_r == ST_OBSERVE);
  assign inj_ready    = INJECT_EN && (st_r == ST_OBSERVE) && !det.valid;
  assign det_take     = det_ready && det.valid;
  assign inj_take     = inj_ready && inj_valid;
  assign cap_req      = cap_r;
  assign ext_req      = ext_r;
  assign rpt          = rpt_r;
  assign startup_done = started_r;
  assign busy         = started_r && (st_r != ST_OBSERVE);

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    started_nxt = started_r;
    det_nxt     = det_r;
    inj_nxt     = inj_r;
    ok_nxt      = ok_r;
    ess_nxt     = ess_r;
    widx_nxt    = widx_r;
    cap_nxt     = cap_r;
    ext_nxt     = ext_r;
    rpt_nxt     = rpt_r;
    rpt_nxt.valid = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (user_mode) begin
          st_nxt  = ST_BOOT;
          cnt_nxt = 32'(BOOT_CYC - 1);
        end
      end
      ST_BOOT: begin
        if (cnt_r == 32'h0) begin
          st_nxt  = ST_INIT;
          cnt_nxt = 32'(INIT_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      ST_INIT: begin
        if (cnt_r == 32'h0) begin
          st_nxt      = ST_OBSERVE;
          started_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      ST_OBSERVE: begin
        // Errors outside configuration memory are dropped here
        if (det_take && det.cfg_mem) begin
          det_nxt = det;
          inj_nxt = 1'b0;
          st_nxt  = ST_LOCATE;
        end else if (inj_take) begin
          det_nxt = '{valid: 1'b1, cfg_mem: 1'b1, loc_valid: 1'b1,
                      nbits: `CMSM_NB_ONE, frame: inj_frame,
                      word: inj_word, bit_idx: inj_bit};
          inj_nxt = 1'b1;
          cap_nxt = '{valid: 1'b1, write: 1'b0, frame: inj_frame,
                      word: inj_word, wdata: 32'h0};
          st_nxt  = ST_RD;
        end
      end
      ST_LOCATE: begin
        ok_nxt = fix_ok;
        if (!fix_ok) begin
          ess_nxt = 1'b0;
          st_nxt  = ST_REPORT;
        end else if (CORR_MODE == `CMSM_MODE_REPLACE) begin
          widx_nxt = 8'h0;
          ext_nxt  = '{valid: 1'b1, cls: 1'b0, frame: det_r.frame,
                       word: 8'h0};
          st_nxt   = ST_FETCH;
        end else begin
          cap_nxt = '{valid: 1'b1, write: 1'b0, frame: det_r.frame,
                      word: det_r.word, wdata: 32'h0};
          st_nxt  = ST_RD;
        end
      end
      ST_RD: begin
        if (cap_ack) begin
          cap_nxt.write = 1'b1;
          cap_nxt.wdata = fix_word;
          st_nxt        = ST_WR;
        end
      end
      ST_FETCH: begin
        if (ext_ack) begin
          ext_nxt.valid = 1'b0;
          cap_nxt = '{valid: 1'b1, write: 1'b1, frame: det_r.frame,
                      word: widx_r, wdata: ext_rdata};
          st_nxt  = ST_WR;
        end
      end
      ST_WR: begin
        if (cap_ack) begin
          cap_nxt.valid = 1'b0;
          if (inj_r) begin
            ess_nxt = 1'b0;
            st_nxt  = ST_REPORT;
          end else if (CORR_MODE == `CMSM_MODE_REPLACE &&
                       widx_r != 8'(FRAME_WORDS - 1)) begin
            widx_nxt = widx_r + 8'h1;
            ext_nxt  = '{valid: 1'b1, cls: 1'b0, frame: det_r.frame,
                         word: widx_r + 8'h1};
            st_nxt   = ST_FETCH;
          end else begin
            st_nxt = ST_CLS;
          end
        end
      end
      ST_CLS: begin
        if (!CLASSIFY_EN) begin
          // Without lookup data every corrected error counts as essential
          ess_nxt = 1'b1;
          st_nxt  = ST_REPORT;
        end else if (!ext_r.valid) begin
          ext_nxt = '{valid: 1'b1, cls: 1'b1, frame: det_r.frame,
                      word: det_r.word};
        end else if (ext_ack) begin
          ext_nxt.valid = 1'b0;
          ess_nxt = ext_rdata[det_r.bit_idx];
          st_nxt  = ST_REPORT;
        end
      end
      ST_REPORT: begin
        rpt_nxt = '{valid: 1'b1, frame: det_r.frame,
                    corrected: ok_r && !inj_r,
                    uncorrectable: !ok_r && !inj_r,
                    essential: ess_r, injected: inj_r};
        st_nxt  = ST_OBSERVE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (inj_nxt && st_r == ST_OBSERVE) begin
      ok_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r      <= ST_IDLE;
      cnt_r     <= 32'h0;
      started_r <= 1'b0;
      det_r     <= '0;
      inj_r     <= 1'b0;
      ok_r      <= 1'b0;
      ess_r     <= 1'b0;
      widx_r    <= 8'h0;
      cap_r     <= '0;
      ext_r     <= '0;
      rpt_r     <= '0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      started_r <= started_nxt;
      det_r     <= det_nxt;
      inj_r     <= inj_nxt;
      ok_r      <= ok_nxt;
      ess_r     <= ess_nxt;
      widx_r    <= widx_nxt;
      cap_r     <= cap_nxt;
      ext_r     <= ext_nxt;
      rpt_r     <= rpt_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence cap_rd_s;
    st_r == ST_RD && cap_r.valid && !cap_r.write;
  endsequence
  sequence fetch_s;
    st_r == ST_FETCH && ext_r.valid && !ext_r.cls;
  endsequence

  boot_on_mode_a: assert property (st_r == ST_IDLE && user_mode |=>
    st_r == ST_BOOT && cnt_r == 32'(BOOT_CYC - 1))
    else $error("boot not started at user mode");
  boot_len_a: assert property (st_r == ST_BOOT && cnt_r == 32'h0 |=>
    st_r == ST_INIT && cnt_r == 32'(INIT_CYC - 1))
    else $error("boot did not hand over to init");
  init_done_a: assert property (st_r == ST_INIT && cnt_r == 32'h0 |=>
    st_r == ST_OBSERVE && startup_done)
    else $error("init did not end in observation");
  start_once_a: assert property (started_r |->
    st_r != ST_BOOT && st_r != ST_INIT && st_r != ST_IDLE)
    else $error("start-up repeated");
  inj_idle_a: assert property (inj_ready |->
    st_r == ST_OBSERVE && !det.valid)
    else $error("injection offered while busy");
  cfg_only_a: assert property (det_take && !det.cfg_mem &&
    !inj_valid |=> st_r == ST_OBSERVE)
    else $error("acted on non-configuration error");
  locate_first_a: assert property (det_take && det.cfg_mem |=>
    st_r == ST_LOCATE ##1 st_r != ST_LOCATE)
    else $error("error not located first");
  one_frame_a: assert property (st_r == ST_LOCATE |-> !det_ready)
    else $error("new frame taken mid-handling");
  repair_one_a: assert property (st_r == ST_LOCATE && det_r.loc_valid &&
    det_r.nbits == `CMSM_NB_ONE && CORR_MODE != `CMSM_MODE_REPLACE |=>
    cap_rd_s)
    else $error("single-bit frame not repaired");
  enh_adj_a: assert property (st_r == ST_LOCATE &&
    CORR_MODE == `CMSM_MODE_ENH && det_r.loc_valid &&
    det_r.nbits == `CMSM_NB_ADJ && det_r.bit_idx != `CMSM_TOP_BIT |=>
    cap_rd_s)
    else $error("adjacent pair not repaired");
  replace_a: assert property (st_r == ST_LOCATE && det_r.loc_valid &&
    CORR_MODE == `CMSM_MODE_REPLACE |=> fetch_s and (ext_r.word == 8'h0))
    else $error("located frame not replaced");
  ext_hold_a: assert property (ext_r.valid && !ext_ack |=>
    ext_r.valid && $stable(ext_r))
    else $error("storage request dropped");
  classify_a: assert property (st_r == ST_CLS && CLASSIFY_EN &&
    !ext_r.valid |=> ext_r.valid && ext_r.cls && ext_r.frame == det_r.frame)
    else $error("corrected error not classified");
  inj_port_a: assert property (inj_take && !det.valid |=>
    cap_rd_s ##0 inj_r && cap_r.frame == $past(inj_frame))
    else $error("injection request not served");
endmodule
`default_nettype wire

// ===== common/cmsm_params.svh
// Function
// - Repair mode fixes any frame holding one flipped bit via ECC syndrome.
// - Enhanced repair fixes one flipped bit or two adjacent flipped bits, unless the pair starts at bit 31.
// - Replace mode rewrites a located frame with original data from storage.
// - Each affected frame runs its own detect, correct, classify pass.
// - After configuration, boot then initialize; start-up ends at observation.
// - Boot time is mode independent; initialization time depends on mode.
// - Start-up happens once and is never repeated for later errors.
// - With classification built in, each corrected error is looked up and judged essential or not.
// - Classification or replace needs external storage that supplies data.
// - Only configuration memory errors are handled; others are ignored.
// - Error injection requests are optionally taken from an outside processor.
// - Injection requests are accepted only while observing and idle.
// - In observation, flagged errors are located before any correction.
`ifndef CMSM_PARAMS_SVH
`define CMSM_PARAMS_SVH
`define CMSM_CLK_MHZ       50
`define CMSM_BOOT_MS       110
`define CMSM_BOOT_CYC      (`CMSM_BOOT_MS * 1000 * `CMSM_CLK_MHZ)
`define CMSM_INIT_CYC_RR   64
`define CMSM_INIT_CYC_ENH  256
`define CMSM_FRAME_WORDS   8
`define CMSM_MODE_REPAIR   2'h0
`define CMSM_MODE_ENH      2'h1
`define CMSM_MODE_REPLACE  2'h2
`define CMSM_NB_ONE        2'h1
`define CMSM_NB_ADJ        2'h2
`define CMSM_NB_MULTI      2'h3
`define CMSM_TOP_BIT       5'h1F
`endif

// ===== common/cmsm_pkg.sv
package cmsm_pkg;

  typedef enum logic [11:0] {
    ST_IDLE    = 12'h001,
    ST_BOOT    = 12'h002,
    ST_INIT    = 12'h004,
    ST_OBSERVE = 12'h008,
    ST_LOCATE  = 12'h010,
    ST_RD      = 12'h020,
    ST_WR      = 12'h040,
    ST_FETCH   = 12'h080,
    ST_CLS     = 12'h100,
    ST_REPORT  = 12'h200
  } cmsm_state_t;

  typedef struct packed {
    logic        valid;
    logic        cfg_mem;
    logic        loc_valid;
    logic [1:0]  nbits;
    logic [15:0] frame;
    logic [7:0]  word;
    logic [4:0]  bit_idx;
  } cmsm_det_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] frame;
    logic [7:0]  word;
    logic [31:0] wdata;
  } cmsm_cap_req_t;

  typedef struct packed {
    logic        valid;
    logic        cls;
    logic [15:0] frame;
    logic [7:0]  word;
  } cmsm_ext_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] frame;
    logic        corrected;
    logic        uncorrectable;
    logic        essential;
    logic        injected;
  } cmsm_rpt_t;

  function automatic logic [31:0] cmsm_bit_mask(input logic [4:0] b);
    cmsm_bit_mask = 32'h0000_0001 << b;
  endfunction

endpackage

// ===== src/cmsm_fix.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmsm_params.svh"
module cmsm_fix
  import cmsm_pkg::*;
(
  input  wire logic [1:0]  mode,
  input  wire logic        inj,
  input  wire cmsm_det_t   det,
  input  wire logic [31:0] rdata,
  output logic      [31:0] fixed,
  output logic             ok
);
  logic [31:0] mask;

  always_comb begin
    ok = 1'b0;
    if (inj) begin
      ok = 1'b1;
    end else if (det.loc_valid) begin
      case (mode)
        `CMSM_MODE_REPAIR:  ok = (det.nbits == `CMSM_NB_ONE);
        `CMSM_MODE_ENH:     ok = (det.nbits == `CMSM_NB_ONE) ||
                                 (det.nbits == `CMSM_NB_ADJ &&
                                  det.bit_idx != `CMSM_TOP_BIT);
        `CMSM_MODE_REPLACE: ok = 1'b1;
        default:            ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    mask = cmsm_bit_mask(det.bit_idx);
    if (!inj && det.nbits == `CMSM_NB_ADJ) begin
      mask = mask | cmsm_bit_mask(5'(det.bit_idx + 5'h1));
    end
    fixed = rdata ^ mask;
  end
endmodule
`default_nettype wire

// ===== verification/cmsm_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmsm_port_model
  import cmsm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [3:0]    dly,
  input  wire cmsm_cap_req_t cap_req,
  output logic               cap_ack,
  output logic      [31:0]   cap_rdata,
  input  wire cmsm_ext_req_t ext_req,
  output logic               ext_ack,
  output logic      [31:0]   ext_rdata
);
  logic [31:0] gold [16][8];
  logic [31:0] cur  [16][8];
  logic [31:0] ess  [16][8];
  logic [3:0]  cap_cnt;
  logic [3:0]  ext_cnt;

  initial begin
    cap_ack   = 1'b0;
    ext_ack   = 1'b0;
    cap_rdata = 32'h0F0F_0F0F;
    ext_rdata = 32'hF0F0_F0F0;
    for (int f = 0; f < 16; f++) begin
      for (int w = 0; w < 8; w++) begin
        gold[f][w] = {8'h5A, 8'(f), 8'(w), 8'hC3};
        cur[f][w]  = gold[f][w];
        ess[f][w]  = 32'h0000_00F0;
      end
    end
  end

  // Answers after dly cycles; data lines toggle outside an answer
  always @(posedge clk) begin
    cap_ack   <= 1'b0;
    cap_rdata <= ~cap_rdata;
    if (srst) begin
      cap_cnt <= 4'h0;
    end else if (cap_req.valid && !cap_ack) begin
      if (cap_cnt == dly) begin
        cap_cnt <= 4'h0;
        cap_ack <= 1'b1;
        if (cap_req.write)
          cur[cap_req.frame[3:0]][cap_req.word[2:0]] <= cap_req.wdata;
        else
          cap_rdata <= cur[cap_req.frame[3:0]][cap_req.word[2:0]];
      end else begin
        cap_cnt <= cap_cnt + 4'h1;
      end
    end
  end

  // Storage supplies original frame data or the essential map
  always @(posedge clk) begin
    ext_ack   <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (srst) begin
      ext_cnt <= 4'h0;
    end else if (ext_req.valid && !ext_ack) begin
      if (ext_cnt == dly) begin
        ext_cnt   <= 4'h0;
        ext_ack   <= 1'b1;
        ext_rdata <= ext_req.cls ? ess[ext_req.frame[3:0]][ext_req.word[2:0]]
                                 : gold[ext_req.frame[3:0]][ext_req.word[2:0]];
      end else begin
        ext_cnt <= ext_cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmsm_params.svh"
module tb_top
  import cmsm_pkg::*;
;
  localparam int BOOT = 20;
  localparam int INIT = 4;

  logic          clk = 1'b0;
  logic          srst;
  logic          user_mode;
  cmsm_det_t     det;
  logic          det_ready;
  logic          inj_valid;
  logic [15:0]   inj_frame;
  logic [7:0]    inj_word;
  logic [4:0]    inj_bit;
  logic          inj_ready;
  cmsm_cap_req_t cap_req;
  logic          cap_ack;
  logic [31:0]   cap_rdata;
  cmsm_ext_req_t ext_req;
  logic          ext_ack;
  logic [31:0]   ext_rdata;
  cmsm_rpt_t     rpt;
  logic          startup_done;
  logic          busy;
  logic [3:0]    pm_dly;
  int            miscompares = 0;
  int            n_tests = 0;
  int            rpt_cnt = 0;

  always #10 clk = ~clk;

  always @(posedge clk)
    if (rpt.valid === 1'b1)
      rpt_cnt++;

  cmsm_top #(.CORR_MODE(`CMSM_MODE_REPAIR), .CLASSIFY_EN(1'b1),
    .INJECT_EN(1'b1), .BOOT_CYC(BOOT), .INIT_RR(INIT), .INIT_ENH(8),
    .FRAME_WORDS(8)) dut (
    .clk(clk), .srst(srst), .user_mode(user_mode), .det(det),
    .det_ready(det_ready), .inj_valid(inj_valid), .inj_frame(inj_frame),
    .inj_word(inj_word), .inj_bit(inj_bit), .inj_ready(inj_ready),
    .cap_req(cap_req), .cap_ack(cap_ack), .cap_rdata(cap_rdata),
    .ext_req(ext_req), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
    .rpt(rpt), .startup_done(startup_done), .busy(busy));

  cmsm_port_model pm (
    .clk(clk), .srst(srst), .dly(pm_dly), .cap_req(cap_req),
    .cap_ack(cap_ack), .cap_rdata(cap_rdata), .ext_req(ext_req),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results;
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_rpt;
    int n;
    for (n = 0; n < 400 && rpt.valid !== 1'b1; n++)
      tick(1);
    chk(n < 400, 1);
  endtask

  task automatic send_det(input logic [15:0] f, input logic [7:0] w,
                          input logic [4:0] b, input logic [1:0] nb,
                          input logic cm);
    int n;
    det = '{1'b1, cm, 1'b1, nb, f, w, b};
    #1;
    chk(inj_ready, 0);
    for (n = 0; n < 400 && det_ready !== 1'b1; n++)
      tick(1);
    tick(1);
    det.valid = 1'b0;
  endtask

  task automatic t_startup;
    int n;
    user_mode = 1'b1;
    tick(3);
    chk({busy, dut.st_r == ST_BOOT}, 2'h1);
    chk(det_ready, 0);
    for (n = 3; n < 100 && startup_done !== 1'b1; n++)
      tick(1);
    chk(n >= BOOT + INIT && n <= BOOT + INIT + 2, 1);
    chk(busy, 0);
  endtask

  task automatic t_repair(input logic [15:0] f, input logic [7:0] w,
                          input logic [4:0] b, input logic ess,
                          input logic flip);
    if (flip)
      pm.cur[f[3:0]][w[2:0]] ^= 32'h1 << b;
    send_det(f, w, b, `CMSM_NB_ONE, 1'b1);
    chk(det_ready, 0);
    chk(inj_ready, 0);
    wait_rpt;
    chk(rpt.frame, f);
    chk({rpt.corrected, rpt.uncorrectable, rpt.injected}, 3'h4);
    chk(rpt.essential, ess);
    chk(pm.cur[f[3:0]][w[2:0]], pm.gold[f[3:0]][w[2:0]]);
    tick(2);
    chk(busy, 0);
    chk(startup_done, 1);
  endtask

  task automatic t_ignore;
    int c;
    c = rpt_cnt;
    send_det(16'h3, 8'h1, 5'h4, `CMSM_NB_ONE, 1'b0);
    tick(20);
    chk(rpt_cnt, c);
    chk(det_ready, 1);
  endtask

  task automatic t_uncorr;
    send_det(16'h9, 8'h3, 5'h2, `CMSM_NB_MULTI, 1'b1);
    wait_rpt;
    chk({rpt.corrected, rpt.uncorrectable}, 2'h1);
    chk(pm.cur[9][3], pm.gold[9][3]);
    tick(2);
  endtask

  task automatic t_inject;
    int n;
    chk(inj_ready, 1);
    inj_frame = 16'h5;
    inj_word  = 8'h2;
    inj_bit   = 5'h7;
    inj_valid = 1'b1;
    for (n = 0; n < 400 && inj_ready !== 1'b1; n++)
      tick(1);
    tick(1);
    inj_valid = 1'b0;
    wait_rpt;
    chk({rpt.injected, rpt.corrected, rpt.essential}, 3'h4);
    chk(pm.cur[5][2], pm.gold[5][2] ^ 32'h80);
    tick(2);
    t_repair(16'h5, 8'h2, 5'h7, 1'b1, 1'b0);
  endtask

  initial begin
    srst      = 1'b1;
    user_mode = 1'b0;
    det       = '0;
    inj_valid = 1'b0;
    inj_frame = 16'h0;
    inj_word  = 8'h0;
    inj_bit   = 5'h0;
    pm_dly    = 4'h0;
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(3);
    chk(startup_done, 0);
    t_startup;
    t_repair(16'h2, 8'h4, 5'h5, 1'b1, 1'b1);
    t_repair(16'h2, 8'h6, 5'h1, 1'b0, 1'b1);
    pm_dly = 4'h3;
    t_repair(16'h7, 8'h0, 5'h1F, 1'b0, 1'b1);
    t_repair(16'h8, 8'h7, 5'h0, 1'b0, 1'b1);
    t_ignore;
    t_uncorr;
    t_inject;
    user_mode = 1'b0;
    tick(2);
    user_mode = 1'b1;
    tick(3);
    chk({busy, startup_done}, 2'h1);
    results;
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #(20 * 5000);
    miscompares++;
    results;
  end
endmodule
`default_nettype wire
